// file: tmpc_tap_motor_pulse_control.sv
/*
 * Holds the switching pulse sequencer, runtime monitor and trip pulse of the tap motor pulse control.
 * Assumes the regulator and panel logic on clk_i supply requests and settings; motor feedback and
 * tap position come from pins and are synchronised here.
 */
`timescale 1ns/1ps
`include "tmpc_params.svh"

module tmpc_tap_motor_pulse_control #(
    parameter logic [`TMPC_PRE_W-1:0] CYC_PER_MS = `TMPC_CYC_PER_MS,   // Cycles in one millisecond.
    parameter int                     POS_W      = `TMPC_POS_W         // Tap position width.
) (
    // Clock, reset and enable.
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    // Settings.
    input  wire logic                  pulse_type_i,
    input  wire logic                  direction_i,
    input  wire logic                  follower_i,
    input  wire logic                  runtime_mon_en_i,
    input  wire logic [`TMPC_MS_W-1:0] pulse_time_ms_i,
    input  wire logic [`TMPC_MS_W-1:0] pulse_pause_ms_i,
    input  wire logic [`TMPC_MS_W-1:0] runtime_limit_ms_i,
    input  wire logic [`TMPC_MS_W-1:0] change_wait_ms_i,
    // Operating mode and requests.
    input  wire logic                  automatic_regulation_mode_i,
    input  wire logic                  manual_operation_mode_i,
    input  wire logic                  auto_raise_req_i,
    input  wire logic                  auto_lower_req_i,
    input  wire logic                  manual_raise_i,
    input  wire logic                  manual_lower_i,
    input  wire logic                  target_reached_i,
    // Motor drive pins.
    input  wire logic                  motor_running_i,
    input  wire logic [POS_W-1:0]      tap_pos_i,
    // Outputs.
    output logic                       raise_o,
    output logic                       lower_o,
    output logic                       runtime_exceeded_o,
    output logic                       trip_o,
    output logic                       busy_o
);

    // Synchroniser stages for the motor pins.
    logic                  run_s1;               // First stage, read only by run_s2.
    logic                  run_s2;               // Synchronised running feedback.
    logic                  run_d;                // Delayed copy for edge detection.
    logic [POS_W-1:0]      pos_s1;               // First stage of tap position.
    logic [POS_W-1:0]      pos_s2;               // Synchronised tap position.
    logic [POS_W-1:0]      pos_d;                // Delayed tap position.
    logic [2:0]            prime;                // Fills with ones after reset; position compare waits for it.
    // Millisecond tick.
    logic [`TMPC_PRE_W-1:0] pre;                 // Prescaler.
    logic                  ms_tick;              // One-cycle tick each millisecond.
    // Sequencer.
    tmpc_pkg::tmpc_state_e state;                // Current state.
    tmpc_pkg::tmpc_state_e next_state;           // Next state.
    logic [`TMPC_MS_W-1:0] tmr;                  // Pulse and pause timer in ms.
    logic                  dir_up;               // Latched direction: increase voltage.
    logic [`TMPC_MS_W-1:0] run_ms;               // Measured motor runtime in ms.
    logic [`TMPC_MS_W-1:0] trip_ms;              // Remaining trip pulse in ms.
    logic                  wait_run;             // Runtime event already fired in this run.
    // Derived combinational terms.
    logic                  up_req;               // Request to increase voltage.
    logic                  dn_req;               // Request to decrease voltage.
    logic                  run_fall;             // Feedback fell from 1 to 0.
    logic                  run_rise;             // Feedback rose.
    logic                  pos_chg;              // Tap position changed.
    logic                  over_limit;           // Runtime limit reached.
    logic                  pulse_end;            // Pulse must end now.

    // Two-flop synchronisers for the motor-drive pins.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_s1 <= 1'b0;
            run_s2 <= 1'b0;
            pos_s1 <= '0;
            pos_s2 <= '0;
        end else if (ce_i) begin
            run_s1 <= motor_running_i;
            run_s2 <= run_s1;
            pos_s1 <= tap_pos_i;
            pos_s2 <= pos_s1;
        end
    end

    // Delayed copies feed the edge and change detectors.
    // The position pins have no idle level, so the first real sample after reset
    // would look like a tap change; the priming chain hides that one cycle.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_d <= 1'b0;
            pos_d <= '0;
            prime <= '0;
        end else if (ce_i) begin
            run_d <= run_s2;
            pos_d <= pos_s2;
            prime <= {prime[1:0], 1'b1};
        end
    end

    assign run_fall = run_d & ~run_s2;
    assign run_rise = run_s2 & ~run_d;
    assign pos_chg  = prime[2] & (pos_s2 != pos_d);

    // Millisecond prescaler gives every time setting its unit.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre <= '0;
        end else if (ce_i) begin
            if (pre >= CYC_PER_MS - 1'b1) begin
                pre <= '0;
            end else begin
                pre <= pre + 1'b1;
            end
        end
    end

    assign ms_tick = (pre >= CYC_PER_MS - 1'b1);

    // Request selection; manual commands count only in manual mode, auto only in auto mode.
    always_comb begin
        up_req = 1'b0;
        dn_req = 1'b0;
        if (manual_operation_mode_i) begin
            up_req = manual_raise_i & ~manual_lower_i;
            dn_req = manual_lower_i & ~manual_raise_i;
        end else if (automatic_regulation_mode_i) begin
            up_req = auto_raise_req_i & ~auto_lower_req_i;
            dn_req = auto_lower_req_i & ~auto_raise_req_i;
        end
    end

    // Runtime check only counts while monitoring is on.
    assign over_limit = runtime_mon_en_i & (run_ms >= runtime_limit_ms_i);

    // Decide when an active pulse ends, per pulse type and mode.
    always_comb begin
        pulse_end = 1'b0;
        if (pulse_type_i == `TMPC_TYPE_TIMED) begin
            // Timed pulse runs its time, cut short by feedback or position change.
            pulse_end = (tmr >= pulse_time_ms_i) | run_rise | pos_chg;
        end else if (follower_i) begin
            pulse_end = over_limit | run_fall | target_reached_i;
        end else if (manual_operation_mode_i) begin
            pulse_end = dir_up ? ~manual_raise_i : ~manual_lower_i;
        end else begin
            // Auto mode: requests drop once the value is back inside the band.
            pulse_end = dir_up ? ~auto_raise_req_i : ~auto_lower_req_i;
        end
    end

    // Sequencer next state.
    always_comb begin
        next_state = state;
        unique case (state)
            tmpc_pkg::TMPC_IDLE: begin
                // Requests arriving during the pause stay pending until here.
                if (up_req | dn_req) begin
                    next_state = tmpc_pkg::TMPC_PULSE;
                end
            end
            tmpc_pkg::TMPC_PULSE: begin
                if (pulse_end) begin
                    next_state = tmpc_pkg::TMPC_PAUSE;
                end
            end
            tmpc_pkg::TMPC_PAUSE: begin
                if (tmr >= pulse_pause_ms_i) begin
                    next_state = tmpc_pkg::TMPC_WAIT;
                end
            end
            tmpc_pkg::TMPC_WAIT: begin
                // Inter-change wait counts after the motor has stopped.
                if (~run_s2 & (tmr >= change_wait_ms_i)) begin
                    next_state = tmpc_pkg::TMPC_IDLE;
                end
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= tmpc_pkg::TMPC_IDLE;
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    // Timer restarts at each state change and counts milliseconds.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tmr <= '0;
        end else if (ce_i) begin
            if (next_state != state) begin
                tmr <= '0;
            end else if (state == tmpc_pkg::TMPC_WAIT && run_s2) begin
                tmr <= '0;
            end else if (ms_tick && tmr != '1) begin
                tmr <= tmr + 1'b1;
            end
        end
    end

    // Direction is latched when a pulse starts.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dir_up <= 1'b0;
        end else if (ce_i) begin
            if (state == tmpc_pkg::TMPC_IDLE && (up_req | dn_req)) begin
                dir_up <= up_req;
            end
        end
    end

    // Output drive; only one output can be high since each branch sets at most one output and clears the other.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            raise_o <= 1'b0;
            lower_o <= 1'b0;
        end else if (ce_i) begin
            if (next_state == tmpc_pkg::TMPC_PULSE) begin
                // Swapped direction exchanges the roles of the outputs.
                if ((state == tmpc_pkg::TMPC_IDLE ? up_req : dir_up) ^ (direction_i == `TMPC_DIR_SWAP)) begin
                    raise_o <= 1'b1;
                    lower_o <= 1'b0;
                end else begin
                    raise_o <= 1'b0;
                    lower_o <= 1'b1;
                end
            end else begin
                raise_o <= 1'b0;
                lower_o <= 1'b0;
            end
        end
    end

    // Motor runtime measurement while feedback is held, which the drive keeps for the whole change.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_ms <= '0;
        end else if (ce_i) begin
            if (~run_s2) begin
                run_ms <= '0;
            end else if (ms_tick && run_ms != '1) begin
                run_ms <= run_ms + 1'b1;
            end
        end
    end

    // Runtime-exceeded event fires once per run when the limit is passed.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            runtime_exceeded_o <= 1'b0;
            wait_run           <= 1'b0;
        end else if (ce_i) begin
            runtime_exceeded_o <= 1'b0;
            if (~run_s2) begin
                wait_run <= 1'b0;
            end else if (over_limit && ~wait_run) begin
                runtime_exceeded_o <= 1'b1;
                wait_run           <= 1'b1;
            end
        end
    end

    // Protective switch trip pulse of fixed length after an event.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            trip_ms <= '0;
        end else if (ce_i) begin
            if (runtime_exceeded_o) begin
                trip_ms <= `TMPC_TRIP_MS;
            end else if (ms_tick && trip_ms != '0) begin
                trip_ms <= trip_ms - 1'b1;
            end
        end
    end

    // Trip output registered from the runtime event and the remaining count.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            trip_o <= 1'b0;
        end else if (ce_i) begin
            trip_o <= runtime_exceeded_o | (trip_ms != '0);
        end
    end

    // Busy shows the sequencer is not ready for a new pulse.
    assign busy_o = (state != tmpc_pkg::TMPC_IDLE);

endmodule // tmpc_tap_motor_pulse_control

// file: tmpc_params.svh
/*
 * Holds the timing, width and encoding constants of the tap motor pulse control block.
 * Assumes a 200 MHz device clock; times are given in milliseconds and the cycles in one millisecond are derived here.
 */
`ifndef TMPC_PARAMS_SVH
`define TMPC_PARAMS_SVH

// Clock rate in kHz, so that a time in ms times this rate gives cycles.
`define TMPC_CLK_KHZ          200000
// Width of every time setting, counted in milliseconds.
`define TMPC_MS_W             16
// Width of the millisecond prescaler.
`define TMPC_PRE_W            18
// Default cycles per millisecond, derived from the clock rate.
`define TMPC_CYC_PER_MS       (`TMPC_CLK_KHZ / 1)
// Width of a tap position.
`define TMPC_POS_W            8
// Length of the trip pulse in milliseconds.
`define TMPC_TRIP_MS          16'h0064
// Pulse type encodings.
`define TMPC_TYPE_CONT        1'b0
`define TMPC_TYPE_TIMED       1'b1
// Direction encodings.
`define TMPC_DIR_STD          1'b0
`define TMPC_DIR_SWAP         1'b1

`endif

// file: tmpc_pkg.sv
/*
 * Holds the types of the tap motor pulse control block.
 * Assumes tmpc_params.svh is available for constants.
 */
package tmpc_pkg;

    // Switching sequencer states, one-hot.
    typedef enum logic [3:0] {
        TMPC_IDLE  = 4'b0001,
        TMPC_PULSE = 4'b0010,
        TMPC_PAUSE = 4'b0100,
        TMPC_WAIT  = 4'b1000
    } tmpc_state_e;

endpackage

// file: tmpc_pulse_monitor.sv
/* Checker of the tap motor pulse control outputs against their causes.
   Assumes the design top module and its parameters; bound to it below. */
`timescale 1ns/1ps
`include "tmpc_params.svh"
module tmpc_pulse_monitor #(
    parameter logic [`TMPC_PRE_W-1:0] CYC_PER_MS = `TMPC_CYC_PER_MS, // Cycles in one ms.
    parameter int                     POS_W      = `TMPC_POS_W       // Tap position width.
) (
    // Clock, reset and settings.
    input wire logic clk_i, rst_i, pulse_type_i, direction_i, follower_i, runtime_mon_en_i,
    input wire logic [`TMPC_MS_W-1:0] pulse_time_ms_i, pulse_pause_ms_i,
    // Requests and motor feedback.
    input wire logic manual_operation_mode_i, auto_raise_req_i, auto_lower_req_i,
    input wire logic manual_raise_i, manual_lower_i, motor_running_i,
    // Outputs under watch.
    input wire logic raise_o, lower_o, runtime_exceeded_o, trip_o
);
    logic        drv;     // A switching output is high.
    logic        up_out;  // Request that maps onto the raise output.
    logic [31:0] gap;     // Cycles since the last pulse ended.
    logic [31:0] len;     // Cycles the present pulse has lasted.
    logic [31:0] min_gap; // Shortest legal gap, as the first ms may be short.
    logic [31:0] max_len; // Longest legal timed pulse.
    assign drv     = raise_o | lower_o;
    assign up_out  = direction_i ? auto_lower_req_i : auto_raise_req_i;
    assign min_gap = (pulse_pause_ms_i == 16'h0) ? 32'h0 : 32'(pulse_pause_ms_i - 16'h1) * 32'(CYC_PER_MS);
    assign max_len = (32'(pulse_time_ms_i) + 32'h1) * 32'(CYC_PER_MS) + 32'h3;
    // Measures pulses and gaps; the gap saturates so the first pulse is free.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gap <= 32'hffffffff;
            len <= 32'h0;
        end else begin
            gap <= drv ? 32'h0 : gap + {31'h0, gap != 32'hffffffff};
            len <= drv ? len + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A released command ends the pulse within two cycles.
    sequence s_drop; ##[1:2] !drv; endsequence
    // Feedback passes the synchroniser, then ends a timed pulse.
    sequence s_early; ##[1:6] !drv; endsequence
    a_never_both: assert property (!(raise_o && lower_o))
        else $error("Raise and lower high together.");
    a_manual_drop: assert property (manual_operation_mode_i && !follower_i && drv && !manual_raise_i
        && !manual_lower_i && pulse_type_i == `TMPC_TYPE_CONT |-> s_drop) else $error("Manual pulse too long.");
    a_pause_kept: assert property ($rose(drv) |-> gap >= min_gap)
        else $error("Pulse pause too short.");
    a_timed_max: assert property (pulse_type_i == `TMPC_TYPE_TIMED && drv |-> len <= max_len)
        else $error("Timed pulse too long.");
    a_timed_early: assert property (pulse_type_i == `TMPC_TYPE_TIMED && drv && $rose(motor_running_i) |-> s_early)
        else $error("Timed pulse ignores feedback.");
    a_trip_after: assert property ($rose(runtime_exceeded_o) |=> trip_o)
        else $error("No trip after runtime event.");
    a_mon_off: assert property (!runtime_mon_en_i && !$past(runtime_mon_en_i) && !$past(runtime_mon_en_i, 2)
        |-> !runtime_exceeded_o) else $error("Runtime event while disabled.");
    a_dir_map: assert property ($rose(raise_o) && !manual_operation_mode_i |-> $past(up_out))
        else $error("Raise output without matching request.");
endmodule // tmpc_pulse_monitor
bind tmpc_tap_motor_pulse_control tmpc_pulse_monitor #(.CYC_PER_MS(CYC_PER_MS), .POS_W(POS_W)) u_mon (
    .clk_i, .rst_i, .pulse_type_i, .direction_i, .follower_i, .runtime_mon_en_i, .pulse_time_ms_i,
    .pulse_pause_ms_i, .manual_operation_mode_i, .auto_raise_req_i, .auto_lower_req_i, .manual_raise_i,
    .manual_lower_i, .motor_running_i, .raise_o, .lower_o, .runtime_exceeded_o, .trip_o);

// file: tmpc_motor_drive_model.sv
/* Behavioural motor-drive unit facing the tap motor pulse control.
   Assumes drive levels from the block; start delay and run time come from the bench. */
`timescale 1ns/1ps
module tmpc_motor_drive_model #(
    parameter int POS_W = 8 // Tap position width.
) (
    // Clock, reset and drive levels.
    input  wire logic clk_i, rst_i, raise_i, lower_i,
    // Start delay and running time in cycles.
    input  wire logic [15:0] delay_i, run_len_i,
    // Feedback pins.
    output logic             motor_running_o,
    output logic [POS_W-1:0] tap_pos_o
);
    logic        drv_q; // Drive level of the last cycle.
    logic        busy;  // A tap change is under way; new drives are ignored.
    logic        up;    // The change moves the tap upwards.
    logic [15:0] cnt;   // Cycles since the change began.
    // Starts a change on a fresh drive, runs the motor, then steps the tap.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            drv_q <= 1'h0;
            busy <= 1'h0;
            up <= 1'h0;
            cnt <= 16'h0;
            motor_running_o <= 1'h0;
            tap_pos_o <= POS_W'(8'h10);
        end else begin
            drv_q <= raise_i | lower_i;
            if (!busy && (raise_i | lower_i) && !drv_q) begin
                busy <= 1'h1;
                up <= raise_i;
                cnt <= 16'h0;
            end else if (busy) begin
                cnt <= cnt + 16'h1;
                if (cnt == delay_i) begin
                    motor_running_o <= 1'h1;
                end
                if (cnt == delay_i + run_len_i) begin
                    motor_running_o <= 1'h0;
                    busy <= 1'h0;
                    tap_pos_o <= up ? tap_pos_o + 1'h1 : tap_pos_o - 1'h1;
                end
            end
        end
    end
endmodule // tmpc_motor_drive_model

// file: tmpc_tap_motor_pulse_control_tb.sv
/* Self-checking bench of the tap motor pulse control.
   Assumes a ten-cycle millisecond so that all settings stay short. */
`timescale 1ns/1ps
`include "tmpc_params.svh"
module tmpc_tap_motor_pulse_control_tb;
    localparam logic [`TMPC_PRE_W-1:0] CYC = 18'h0000a; // Cycles in one simulated ms.
    // Settings, modes and requests driven by the bench.
    logic clk_i = 1'h0, rst_i = 1'h1, pulse_type_i = 1'h0, direction_i = 1'h0, follower_i = 1'h0;
    logic runtime_mon_en_i = 1'h1, automatic_regulation_mode_i = 1'h1, manual_operation_mode_i = 1'h0;
    logic auto_raise_req_i = 1'h0, auto_lower_req_i = 1'h0, manual_raise_i = 1'h0, manual_lower_i = 1'h0;
    logic target_reached_i = 1'h0;
    logic [`TMPC_MS_W-1:0] pulse_time_ms_i = 16'h3, pulse_pause_ms_i = 16'h4;
    logic [`TMPC_MS_W-1:0] runtime_limit_ms_i = 16'h64, change_wait_ms_i = 16'h1;
    logic [15:0] run_delay = 16'h4, run_len = 16'h14; // Partner start delay and running time.
    // Partner feedback and design outputs.
    logic motor_running_i, raise_o, lower_o, runtime_exceeded_o, trip_o, busy_o;
    logic [`TMPC_POS_W-1:0] tap_pos_i;
    int fail_count = 0, comparisons = 0, cycles = 0, t, n, ev;
    always #2.5 clk_i = ~clk_i;
    tmpc_tap_motor_pulse_control #(.CYC_PER_MS(CYC), .POS_W(`TMPC_POS_W)) u_dut (.clk_i, .rst_i, .ce_i(1'h1),
        .pulse_type_i, .direction_i, .follower_i, .runtime_mon_en_i, .pulse_time_ms_i, .pulse_pause_ms_i,
        .runtime_limit_ms_i, .change_wait_ms_i, .automatic_regulation_mode_i, .manual_operation_mode_i,
        .auto_raise_req_i, .auto_lower_req_i, .manual_raise_i, .manual_lower_i, .target_reached_i,
        .motor_running_i, .tap_pos_i, .raise_o, .lower_o, .runtime_exceeded_o, .trip_o, .busy_o);
    tmpc_motor_drive_model #(.POS_W(`TMPC_POS_W)) u_drive (.clk_i, .rst_i, .raise_i(raise_o), .lower_i(lower_o),
        .delay_i(run_delay), .run_len_i(run_len), .motor_running_o(motor_running_i), .tap_pos_o(tap_pos_i));
    // Compares a seen value with the expected one and counts both outcomes.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Prints the verdict and ends the run.
    task automatic test_done;
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Counts falling edges until a switching output is high.
    task automatic wait_drive(output int w);
        w = 0;
        while (raise_o !== 1'h1 && lower_o !== 1'h1 && w < 3000) begin
            @(negedge clk_i);
            w++;
        end
    endtask
    // Counts falling edges while a switching output stays high.
    task automatic pulse_len(output int w);
        w = 0;
        while ((raise_o | lower_o) === 1'h1 && w < 3000) begin
            @(negedge clk_i);
            w++;
        end
    endtask
    // Drops every request, checks the pulse ends, then waits for the sequencer to rest.
    task automatic idle;
        int k;
        @(posedge clk_i);
        auto_raise_req_i <= 1'h0;
        auto_lower_req_i <= 1'h0;
        manual_raise_i <= 1'h0;
        manual_lower_i <= 1'h0;
        target_reached_i <= 1'h0;
        repeat (3) @(negedge clk_i);
        check(raise_o | lower_o, 1'h0);
        k = 0;
        while (busy_o !== 1'h0 && k < 5000) begin
            @(negedge clk_i);
            k++;
        end
        check(busy_o, 1'h0);
    endtask
    // Cuts a hang short.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'h0;
        @(negedge clk_i);
        check({raise_o, lower_o, runtime_exceeded_o, trip_o, busy_o}, 5'h0);
        // Both request directions with standard and swapped outputs.
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            direction_i <= k[1];
            auto_raise_req_i <= k[0];
            auto_lower_req_i <= !k[0];
            wait_drive(t);
            check({raise_o, lower_o}, (k[0] ^ k[1]) ? 2'h2 : 2'h1);
            repeat (40) @(negedge clk_i);
            check(raise_o | lower_o, 1'h1);
            idle();
        end
        // Manual command held, then both commands at once.
        @(posedge clk_i);
        direction_i <= `TMPC_DIR_STD;
        manual_operation_mode_i <= 1'h1;
        manual_lower_i <= 1'h1;
        wait_drive(t);
        repeat (30) @(negedge clk_i);
        check({raise_o, lower_o}, 2'h1);
        idle();
        @(posedge clk_i);
        manual_raise_i <= 1'h1;
        manual_lower_i <= 1'h1;
        repeat (20) @(negedge clk_i);
        check(busy_o, 1'h0);
        idle();
        // Timed pulses: full length, pause, then an early end on feedback.
        @(posedge clk_i);
        manual_operation_mode_i <= 1'h0;
        pulse_type_i <= `TMPC_TYPE_TIMED;
        run_delay <= 16'h3c;
        auto_raise_req_i <= 1'h1;
        wait_drive(t);
        pulse_len(n);
        check(n >= 20 && n <= 43, 1'h1);
        wait_drive(t);
        check(t >= 30, 1'h1);
        pulse_len(n);
        check(n >= 20 && n <= 43, 1'h1);
        idle();
        @(posedge clk_i);
        run_delay <= 16'h4;
        auto_raise_req_i <= 1'h1;
        wait_drive(t);
        pulse_len(n);
        check(n <= 14, 1'h1);
        idle();
        // Follower ends on motor stop, then on the master's target.
        @(posedge clk_i);
        pulse_type_i <= `TMPC_TYPE_CONT;
        follower_i <= 1'h1;
        auto_raise_req_i <= 1'h1;
        wait_drive(t);
        pulse_len(n);
        check(n >= 24 && n <= 38, 1'h1);
        @(posedge clk_i);
        run_len <= 16'hc8;
        wait_drive(t);
        repeat (10) @(posedge clk_i);
        target_reached_i <= 1'h1;
        pulse_len(n);
        check(n <= 3, 1'h1);
        idle();
        // Runtime limit with monitoring on, then off.
        @(posedge clk_i);
        follower_i <= 1'h0;
        runtime_limit_ms_i <= 16'h3;
        run_len <= 16'h50;
        auto_raise_req_i <= 1'h1;
        t = 0;
        while (runtime_exceeded_o !== 1'h1 && t < 300) begin
            @(negedge clk_i);
            t++;
        end
        check(t >= 20 && t < 120, 1'h1);
        @(negedge clk_i);
        check(trip_o, 1'h1);
        idle();
        @(posedge clk_i);
        runtime_mon_en_i <= 1'h0;
        auto_raise_req_i <= 1'h1;
        ev = 0;
        repeat (150) begin
            @(negedge clk_i);
            if (runtime_exceeded_o !== 1'h0) ev++;
        end
        check(ev, 0);
        idle();
        // Neither mode active: regulator requests are ignored.
        @(posedge clk_i);
        automatic_regulation_mode_i <= 1'h0;
        auto_raise_req_i <= 1'h1;
        repeat (20) @(negedge clk_i);
        check(busy_o, 1'h0);
        idle();
        test_done();
    end
endmodule // tmpc_tap_motor_pulse_control_tb
